//--- hw/orl_pkg.sv
package orl_pkg;

   // ***********************************************
   // Register map, byte addresses on the host link
   // ***********************************************
   localparam logic [7:0] ADDR_VOLT_LO = 8'h06;
   localparam logic [7:0] ADDR_VOLT_HI = 8'h07;
   localparam logic [7:0] ADDR_CUR_LO = 8'h08;
   localparam logic [7:0] ADDR_CUR_HI = 8'h09;

   // ***********************************************
   // Reset values
   // ***********************************************
   localparam logic [15:0] VOLT_RESET = 16'h09c4;
   localparam logic [15:0] CUR_RESET = 16'h3c00;

   // ***********************************************
   // Field layout
   // ***********************************************
   localparam int VOLT_FIELD_LSB = 2;
   localparam int VOLT_FIELD_W = 12;
   localparam int VOLT_RSVD_LSB = 14;
   localparam int CUR_FIELD_W = 7;
   localparam int CUR_RSVD_BIT = 7;
   localparam logic [7:0] VOLT_LO_KEEP_MASK = 8'hfc;
   localparam logic [7:0] VOLT_HI_RSVD_MASK = 8'hc0;
   localparam logic [7:0] CUR_HI_RSVD_MASK = 8'h80;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // ***********************************************
   // Voltage window and weights
   // ***********************************************
   localparam int VOLT_STEP_MV = 8;
   localparam int VOLT_MIN_MV = 3000;
   localparam int VOLT_MAX_MV = 24000;
   localparam int CUR_STEP_MA = 50;
   localparam int VOLT_MIN_CODE = (VOLT_MIN_MV + VOLT_STEP_MV - 1) / VOLT_STEP_MV;
   localparam int VOLT_MAX_CODE = VOLT_MAX_MV / VOLT_STEP_MV;

   // ***********************************************
   // Carriers
   // ***********************************************
   typedef struct packed {
      logic valid;
      logic [7:0] addr;
      logic [7:0] data;
   } orl_wr_req_t;

   typedef struct packed {
      logic valid;
      logic [7:0] addr;
   } orl_rd_req_t;

endpackage : orl_pkg

//--- hw/orl_range_check.sv
module orl_range_check
#(
   parameter int CODE_W = 12,
   parameter int MIN_CODE = 375,
   parameter int MAX_CODE = 3000
)
(
   code,
   in_range
);
   input wire logic [CODE_W-1:0] code;
   output logic in_range;

   // Refuse windows that the code width cannot hold
   generate
      if (MIN_CODE > MAX_CODE || MAX_CODE >= (1 << CODE_W))
      begin : g_bad_window
         $error("orl_range_check: voltage window does not fit the code");
      end
   endgenerate

   localparam logic [CODE_W-1:0] LO = CODE_W'(MIN_CODE);
   localparam logic [CODE_W-1:0] HI = CODE_W'(MAX_CODE);

   // Code lies inside the allowed setpoint window, both ends included
   assign in_range = (code >= LO) && (code <= HI);

endmodule : orl_range_check

//--- hw/orl_regs.sv
// Functional notes
// - The voltage setpoint is a 12-bit code in bits 13..2 of the voltage register, 8 mV per LSB.
// - A one written into voltage bits 15-14 or current upper-byte bit 7 is an invalid write, which the host avoids.
// - Voltage register bits 1-0 have no function and whatever is written there is dropped.
// - The voltage register resets to 09C4h, a 5000 mV setpoint.
// - The current limit is a 7-bit code in bits 6..0 of the current upper byte, 50 mA per LSB.
// - The current register resets to 3C00h, a 3000 mA limit.
// - Voltage writes outside 3 V to 24.0 V are ignored and the previous setpoint is kept.
module orl_regs
#(
   parameter int VCODE_W = orl_pkg::VOLT_FIELD_W,
   parameter int ICODE_W = orl_pkg::CUR_FIELD_W
)
(
   input wire logic clock,
   input wire logic srst,
   input wire orl_pkg::orl_wr_req_t wr_req,
   input wire orl_pkg::orl_rd_req_t rd_req,
   output logic wr_ack_r,
   output logic rd_ack_r,
   output logic [7:0] rd_data_r,
   output logic invalid_write_r,
   output logic range_reject_r,
   output logic [VCODE_W-1:0] vout_code_r,
   output logic [ICODE_W-1:0] ilim_code_r
);
   import orl_pkg::*;

   // ***********************************************
   // Elaboration checks
   // ***********************************************
   // Field widths are fixed by the register layout
   generate
      if (VCODE_W != VOLT_FIELD_W || ICODE_W != CUR_FIELD_W)
      begin : g_bad_width
         $error("orl_regs: field widths are fixed by the register layout");
      end
   endgenerate

   // Reset words must keep the reserved bits clear
   generate
      if ((VOLT_RESET[15:8] & VOLT_HI_RSVD_MASK) != 8'h00 || (CUR_RESET[15:8] & CUR_HI_RSVD_MASK) != 8'h00)
      begin : g_bad_reset
         $error("orl_regs: reset values set reserved bits");
      end
   endgenerate

   // ***********************************************
   // Address decode
   // ***********************************************

   // Bit positions of the register bytes in a one-hot select
   localparam int SEL_VOLT_LO = 0;
   localparam int SEL_VOLT_HI = 1;
   localparam int SEL_CUR_LO = 2;
   localparam int SEL_CUR_HI = 3;

   // One-hot select for a byte address; shared by the write and read paths
   function automatic logic [3:0] addr_sel(input logic [7:0] addr);
      logic [3:0] sel;
      sel = 4'h0;
      sel[SEL_VOLT_LO] = (addr == ADDR_VOLT_LO);
      sel[SEL_VOLT_HI] = (addr == ADDR_VOLT_HI);
      sel[SEL_CUR_LO] = (addr == ADDR_CUR_LO);
      sel[SEL_CUR_HI] = (addr == ADDR_CUR_HI);
      return sel;
   endfunction : addr_sel

   // ***********************************************
   // Stored state
   // ***********************************************
   logic [15:0] volt_r;
   logic [15:0] volt_nxt;
   logic [7:0] volt_lo_stage_r;
   logic [7:0] volt_lo_stage_nxt;
   // Only the upper current byte is kept; its lower byte has no function
   logic [7:0] cur_hi_r;
   logic [7:0] cur_hi_nxt;
   logic [7:0] rd_data_nxt;
   logic invalid_nxt;
   logic reject_nxt;

   // ***********************************************
   // Write decode
   // ***********************************************
   // Byte selects, candidate word and commit strobes
   logic [3:0] wr_sel;
   logic [3:0] rd_sel;
   logic hit_volt_lo;
   logic hit_volt_hi;
   logic hit_cur_lo;
   logic hit_cur_hi;
   logic volt_rsvd_set;
   logic cur_rsvd_set;
   logic [15:0] volt_cand;
   logic [VCODE_W-1:0] cand_code;
   logic cand_in_range;
   logic volt_commit;
   logic cur_commit;

   // Address matches for the incoming byte write
   assign wr_sel = wr_req.valid ? addr_sel(wr_req.addr) : 4'h0;
   assign hit_volt_lo = wr_sel[SEL_VOLT_LO];
   assign hit_volt_hi = wr_sel[SEL_VOLT_HI];
   assign hit_cur_lo = wr_sel[SEL_CUR_LO];
   assign hit_cur_hi = wr_sel[SEL_CUR_HI];

   // Reserved top bits set by the host mark the write invalid
   assign volt_rsvd_set = hit_volt_hi && ((wr_req.data & VOLT_HI_RSVD_MASK) != 8'h00);
   assign cur_rsvd_set = hit_cur_hi && ((wr_req.data & CUR_HI_RSVD_MASK) != 8'h00);

   // Candidate 16-bit word: new upper byte with the staged lower byte
   assign volt_cand = {wr_req.data, volt_lo_stage_r & VOLT_LO_KEEP_MASK};
   assign cand_code = volt_cand[VOLT_FIELD_LSB +: VOLT_FIELD_W];

   // Window check on the candidate setpoint
   orl_range_check #(
      .CODE_W(VCODE_W),
      .MIN_CODE(VOLT_MIN_CODE),
      .MAX_CODE(VOLT_MAX_CODE)
   ) u_range (
      .code(cand_code),
      .in_range(cand_in_range)
   );

   // A reserved-bit violation wins over the window check, so only one status pulse fires
   // Commit only clean, in-window words; otherwise the old value stays
   assign volt_commit = hit_volt_hi && !volt_rsvd_set && cand_in_range;
   assign cur_commit = hit_cur_hi && !cur_rsvd_set;

   // ***********************************************
   // Next-state selection
   // ***********************************************

   // Lower voltage byte waits in a stage until its upper byte arrives
   // The stage outlives a refused upper-byte write and is reused by the next one
   assign volt_lo_stage_nxt = hit_volt_lo ? (wr_req.data & VOLT_LO_KEEP_MASK) : volt_lo_stage_r;
   assign volt_nxt = volt_commit ? volt_cand : volt_r;
   assign cur_hi_nxt = cur_commit ? wr_req.data : cur_hi_r;

   // Status pulses for refused writes
   assign invalid_nxt = volt_rsvd_set || cur_rsvd_set;
   assign reject_nxt = hit_volt_hi && !volt_rsvd_set && !cand_in_range;

   // ***********************************************
   // Read decode
   // ***********************************************

   // Address match for the incoming byte read
   assign rd_sel = rd_req.valid ? addr_sel(rd_req.addr) : 4'h0;

   // A read and a write in one cycle: the read returns the value before the write
   // Committed values are returned; the current low byte reads as zero
   assign rd_data_nxt = rd_sel[SEL_VOLT_LO] ? volt_r[7:0] :
                        rd_sel[SEL_VOLT_HI] ? volt_r[15:8] :
                        rd_sel[SEL_CUR_LO] ? CUR_RESET[7:0] :
                        rd_sel[SEL_CUR_HI] ? cur_hi_r :
                        READ_UNMAPPED;

   // ***********************************************
   // Registers
   // ***********************************************

   // The stage resets to the low byte of the default word, so a lone
   // upper-byte write after reset still pairs with a clean lower byte
   // Configuration storage with documented reset values
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         volt_r <= VOLT_RESET;
         volt_lo_stage_r <= VOLT_RESET[7:0];
         cur_hi_r <= CUR_RESET[15:8];
      end
      else
      begin
         volt_r <= volt_nxt;
         volt_lo_stage_r <= volt_lo_stage_nxt;
         cur_hi_r <= cur_hi_nxt;
      end
   end

   // Setpoint outputs mirror the stored fields
   // Fed from the next value so the outputs move on the same edge as the storage
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         vout_code_r <= VOLT_RESET[VOLT_FIELD_LSB +: VOLT_FIELD_W];
         ilim_code_r <= CUR_RESET[8 +: CUR_FIELD_W];
      end
      else
      begin
         vout_code_r <= volt_nxt[VOLT_FIELD_LSB +: VOLT_FIELD_W];
         ilim_code_r <= cur_hi_nxt[CUR_FIELD_W-1:0];
      end
   end

   // Bus answers and status pulses
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         wr_ack_r <= 1'b0;
         rd_ack_r <= 1'b0;
         rd_data_r <= 8'h00;
         invalid_write_r <= 1'b0;
         range_reject_r <= 1'b0;
      end
      else
      begin
         wr_ack_r <= wr_req.valid;
         rd_ack_r <= rd_req.valid;
         rd_data_r <= rd_data_nxt;
         invalid_write_r <= invalid_nxt;
         range_reject_r <= reject_nxt;
      end
   end

endmodule : orl_regs

//--- sim/orl_regs_asserts.sv
module orl_regs_asserts
   import orl_pkg::*;
#(
   parameter int VCODE_W = 12,
   parameter int ICODE_W = 7
)
(
   input wire logic clock,
   input wire logic srst,
   input wire orl_wr_req_t wr_req,
   input wire orl_rd_req_t rd_req,
   input wire logic wr_ack_r,
   input wire logic rd_ack_r,
   input wire logic [7:0] rd_data_r,
   input wire logic invalid_write_r,
   input wire logic range_reject_r,
   input wire logic [VCODE_W-1:0] vout_code_r,
   input wire logic [ICODE_W-1:0] ilim_code_r
);
   // ****
   // Properties
   // ****
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   sequence s_lo; wr_req.valid && wr_req.addr == 8'h06; endsequence
   sequence s_hi; wr_req.valid && wr_req.addr == 8'h07; endsequence
   sequence s_cur; wr_req.valid && wr_req.addr == 8'h09; endsequence
   sequence s_pair; s_lo ##1 !wr_req.valid ##1 (s_hi and wr_req.data[7:6] == 2'b00); endsequence
   property p_ack; s_cur |=> wr_ack_r; endproperty
   property p_inv_v; s_hi and wr_req.data[7:6] != 2'b00 |=> invalid_write_r && $stable(vout_code_r); endproperty
   property p_inv_i; s_cur and wr_req.data[7] |=> invalid_write_r && $stable(ilim_code_r); endproperty
   property p_ilim; s_cur and !wr_req.data[7] |=> ilim_code_r == $past(wr_req.data[6:0]); endproperty
   property p_lo; s_lo |=> $stable(vout_code_r); endproperty
   property p_pair; s_pair |=> range_reject_r || vout_code_r == {$past(wr_req.data[5:0]), $past(wr_req.data[7:2], 3)};
   endproperty
   property p_chg; $changed(vout_code_r) |-> $past(wr_req.valid && wr_req.addr == 8'h07); endproperty
   property p_rej; range_reject_r |-> $stable(vout_code_r) && !invalid_write_r; endproperty
   property p_win; vout_code_r >= VOLT_MIN_CODE && vout_code_r <= VOLT_MAX_CODE; endproperty
   a_ack: assert property (p_ack) else $error("no write ack");
   a_inv_v: assert property (p_inv_v) else $error("voltage reserved write");
   a_inv_i: assert property (p_inv_i) else $error("current reserved write");
   a_ilim: assert property (p_ilim) else $error("current code");
   a_lo: assert property (p_lo) else $error("low byte visible");
   a_pair: assert property (p_pair) else $error("voltage code");
   a_chg: assert property (p_chg) else $error("voltage moved");
   a_rej: assert property (p_rej) else $error("reject moved");
   a_win: assert property (p_win) else $error("voltage window");
endmodule : orl_regs_asserts

bind orl_regs orl_regs_asserts #(.VCODE_W(VCODE_W), .ICODE_W(ICODE_W)) orl_regs_asserts_i (.clock(clock),
   .srst(srst), .wr_req(wr_req), .rd_req(rd_req), .wr_ack_r(wr_ack_r), .rd_ack_r(rd_ack_r), .rd_data_r(rd_data_r),
   .invalid_write_r(invalid_write_r), .range_reject_r(range_reject_r), .vout_code_r(vout_code_r),
   .ilim_code_r(ilim_code_r));

//--- sim/orl_host_model.sv
module orl_host_model
(
   input wire logic clock,
   output orl_pkg::orl_wr_req_t wr_req,
   output orl_pkg::orl_rd_req_t rd_req,
   input wire logic [7:0] rd_data_r,
   input wire logic [3:0] resp
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle host lines
   initial wr_req = '0;
   initial rd_req = '0;
   // One byte write for a single edge; the one-cycle answer is taken, then released lines show the inverse
   task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [2:0] st);
      @(negedge clock);
      wr_req = '{valid: 1'b1, addr: a, data: d};
      @(negedge clock);
      st = resp[2:0];
      wr_req = '{valid: 1'b0, addr: ~a, data: ~d};
   endtask : wr
   // One byte read; data is taken while the acknowledge stands
   task automatic rd(input logic [7:0] a, output logic [8:0] r);
      @(negedge clock);
      rd_req = '{valid: 1'b1, addr: a};
      @(negedge clock);
      r = {resp[3], rd_data_r};
      rd_req = '{valid: 1'b0, addr: ~a};
   endtask : rd
endmodule : orl_host_model

//--- sim/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic srst = 1'b1;
   orl_pkg::orl_wr_req_t wr_req;
   orl_pkg::orl_rd_req_t rd_req;
   wire [3:0] resp;
   logic [7:0] rd_data_r;
   logic [11:0] vout_code_r;
   logic [6:0] ilim_code_r;
   int error_cnt = 0;
   int checked = 0;
   int cyc = 0;
   always #20 clock = ~clock;
   orl_regs orl_regs_i (.clock(clock), .srst(srst), .wr_req(wr_req), .rd_req(rd_req), .wr_ack_r(resp[2]),
      .rd_ack_r(resp[3]), .rd_data_r(rd_data_r), .invalid_write_r(resp[1]), .range_reject_r(resp[0]),
      .vout_code_r(vout_code_r), .ilim_code_r(ilim_code_r));
   orl_host_model orl_host_model_i (.clock(clock), .wr_req(wr_req), .rd_req(rd_req), .rd_data_r(rd_data_r),
      .resp(resp));
   // ****
   // Checking helpers
   // ****
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wrc(input logic [7:0] a, input logic [7:0] d, input logic [2:0] e);
      logic [2:0] st;
      orl_host_model_i.wr(a, d, st);
      chk(16'(st), 16'(e));
   endtask : wrc
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      logic [8:0] r;
      orl_host_model_i.rd(a, r);
      chk(16'(r), {8'h01, e});
   endtask : rdc
   task automatic final_report();
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report
   // Scenarios
   task automatic t_volt();
      logic [31:0] tbl [4] = '{32'hdc050177, 32'hd8051177, 32'he02e0bb8, 32'he42e1bb8};
      wrc(8'h06, 8'hb9, 3'b100);
      chk(16'(vout_code_r), 16'h0271);
      wrc(8'h07, 8'h0b, 3'b100);
      chk(16'(vout_code_r), 16'h02ee);
      rdc(8'h06, 8'hb8);
      wrc(8'h06, 8'h00, 3'b100);
      wrc(8'h07, 8'h20, 3'b100);
      chk(16'(vout_code_r), 16'h0800);
      foreach (tbl[i])
      begin
         wrc(8'h06, tbl[i][31:24], 3'b100);
         wrc(8'h07, tbl[i][23:16], {2'b10, tbl[i][12]});
         chk(16'(vout_code_r), 16'(tbl[i][11:0]));
      end
   endtask : t_volt
   task automatic t_rsvd();
      wrc(8'h07, 8'h4b, 3'b110);
      wrc(8'h07, 8'hc0, 3'b110);
      chk(16'(vout_code_r), 16'h0bb8);
      wrc(8'h09, 8'ha0, 3'b110);
      chk(16'(ilim_code_r), 16'h003c);
   endtask : t_rsvd
   task automatic t_cur();
      wrc(8'h09, 8'h7f, 3'b100);
      chk(16'(ilim_code_r), 16'h007f);
      wrc(8'h08, 8'hff, 3'b100);
      rdc(8'h08, 8'h00);
      rdc(8'h09, 8'h7f);
      wrc(8'h09, 8'h01, 3'b100);
      chk(16'(ilim_code_r), 16'h0001);
      rdc(8'h30, 8'h00);
   endtask : t_cur
   // Hang guard
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 1000)
      begin
         error_cnt++;
         final_report();
      end
   end
   // Main sequence
   initial
   begin
      repeat (3) @(negedge clock);
      srst = 1'b0;
      chk(16'(vout_code_r), 16'h0271);
      chk(16'(ilim_code_r), 16'h003c);
      rdc(8'h06, 8'hc4);
      rdc(8'h07, 8'h09);
      rdc(8'h09, 8'h3c);
      t_volt();
      t_rsvd();
      t_cur();
      final_report();
   end
endmodule : testbench
